// ---- core/usbrs_pkg.sv ----
package usbrs_pkg;
  // ==========================================================================
  // Register map (byte addresses, one aligned 32-bit word each)
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] IER3_OFF   = 8'h04;
  localparam logic [7:0] IFR3_OFF   = 8'h08;
  localparam logic [7:0] STAT_OFF   = 8'h0C;
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam int         FLAG_W     = 8;

  // ==========================================================================
  // Field positions
  localparam int CTRL_CORE_RST_BIT  = 0;
  localparam int CTRL_IFACE_RST_BIT = 1;
  localparam int IFR3_CK48_BIT      = 0;
  localparam int IFR3_VBUS_OFF_BIT  = 1;
  localparam int IFR3_EVT_LSB       = 2;
  localparam int EVT_W              = FLAG_W - IFR3_EVT_LSB;
  localparam int STAT_VBUS_BIT      = 0;
  localparam int STAT_CK48_BIT      = 1;
  localparam int STAT_SYNC_BIT      = 2;
  localparam int PIN_W              = 2;
  localparam int PIN_CK48           = 0;
  localparam int PIN_VBUS           = 1;

  // ==========================================================================
  // Reset values
  localparam logic              IFACE_RST_INIT = 1'b1;
  localparam logic              CORE_RST_INIT  = 1'b1;
  localparam logic [FLAG_W-1:0] IER3_INIT      = 8'h00;
  localparam logic [FLAG_W-1:0] IFR3_INIT      = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_WORD      = 32'h0000_0000;

  typedef enum logic [1:0] {USBRS_RD, USBRS_WR_CTRL, USBRS_WR_IER, USBRS_WR_IFR} usbrs_acc_t;
endpackage

// ---- core/usbrs_pin_if.sv ----
`timescale 1ns/1ps
interface usbrs_pin_if #(parameter int WIDTH = 2);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  modport filt (input raw, output level);
  modport user (output raw, input level);
endinterface

// ---- core/usbrs_pin_filter.sv ----
`timescale 1ns/1ps
module usbrs_pin_filter
  import usbrs_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Pins in, filtered levels out
  usbrs_pin_if.filt   pins
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] lvl_reg;
  logic [WIDTH-1:0] lvl_next;

  // ==========================================================================
  // Agreement filter
  // A level is taken only when the second and third stages agree, so a
  // metastable settle in the first stage cannot reach the block.
  always_comb
  begin
    lvl_next = lvl_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      s1_reg  <= pins.raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign pins.level = lvl_reg;
endmodule // usbrs_pin_filter

// ---- core/usbrs_seq.sv ----
// Behaviour
// RULE_01 - Interface soft reset starts set after reset
// RULE_02 - Interface reset clears all but three items
// RULE_03 - Software clears interface reset after clock stable
// RULE_04 - Re-setting interface reset also sets core reset
// RULE_05 - Core soft reset starts set after reset
// RULE_06 - Core reset holds core, stops bus sync
// RULE_07 - Software clears core reset after pull-up enabled
// RULE_08 - On suspend keep core reset clear
// RULE_09 - Set core reset after VBUS loss only
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module usbrs_seq
  import usbrs_pkg::*;
(
  // APB clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pins from outside the clock domain
  input  wire logic              clk48_stable_pin,
  input  wire logic              vbus_pin,
  // Events from the interface logic, one-cycle pulses
  input  wire logic [EVT_W-1:0]  usb_event,
  // Reset and enable outputs to the function module
  output logic                   interface_reset_out,
  output logic                   core_reset_out,
  output logic                   bus_sync_enable,
  output logic [FLAG_W-1:0]      interrupt_enable_out
);
  usbrs_pin_if #(.WIDTH(PIN_W)) pin_bus ();

  assign pin_bus.raw[PIN_CK48] = clk48_stable_pin;
  assign pin_bus.raw[PIN_VBUS] = vbus_pin;

  usbrs_pin_filter #(.WIDTH(PIN_W)) u_filter
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (pin_bus)
  );

  logic ck48_ready;
  logic vbus_on;

  assign ck48_ready = pin_bus.level[PIN_CK48];
  assign vbus_on    = pin_bus.level[PIN_VBUS];

  // ==========================================================================
  // Register state
  logic              iface_rst_reg;
  logic              iface_rst_next;
  logic              core_rst_reg;
  logic              core_rst_next;
  logic [FLAG_W-1:0] ier3_reg;
  logic [FLAG_W-1:0] ier3_next;
  logic [FLAG_W-1:0] ifr3_reg;
  logic [FLAG_W-1:0] ifr3_next;
  logic              vbus_d_reg;
  logic              vbus_d_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              pready_reg;
  logic              iface_out_reg;
  logic              core_out_reg;
  logic              sync_en_reg;
  logic              sync_en_next;

  logic              wr_access;
  logic              setup;

  assign wr_access = psel && penable && pwrite;
  assign setup     = psel && !penable;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFF) || (a == IER3_OFF) || (a == IFR3_OFF) || (a == STAT_OFF);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [FLAG_W-1:0] v);
    return {{(DATA_W-FLAG_W){1'b0}}, v};
  endfunction

  // ==========================================================================
  // Control register and flags
  always_comb
  begin
    iface_rst_next = iface_rst_reg;
    core_rst_next  = core_rst_reg;
    ier3_next      = ier3_reg;
    ifr3_next      = ifr3_reg;
    vbus_d_next    = vbus_on;
    if (wr_access && paddr == CTRL_OFF)
    begin
      iface_rst_next = pwdata[CTRL_IFACE_RST_BIT];
      core_rst_next  = pwdata[CTRL_CORE_RST_BIT];
      // RULE_04 core follows interface
      // Software must set both together; hardware forces core reset only when
      // interface reset goes from clear to set; a write while it is already set can clear core.
      if (pwdata[CTRL_IFACE_RST_BIT] && !iface_rst_reg)
      begin
        core_rst_next = 1'b1;
      end
    end
    // RULE_02 enable register kept
    if (wr_access && paddr == IER3_OFF)
    begin
      ier3_next = pwdata[FLAG_W-1:0];
    end
    if (wr_access && paddr == IFR3_OFF)
    begin
      ifr3_next = ifr3_reg & ~pwdata[FLAG_W-1:0];
    end
    // RULE_09 vbus loss flagged
    if (vbus_d_reg && !vbus_on)
    begin
      ifr3_next[IFR3_VBUS_OFF_BIT] = 1'b1;
    end
    ifr3_next[FLAG_W-1:IFR3_EVT_LSB] = ifr3_next[FLAG_W-1:IFR3_EVT_LSB] | usb_event;
    // RULE_02 flags held clear
    if (iface_rst_reg)
    begin
      ifr3_next = IFR3_INIT;
    end
    // RULE_02 clock-ready flag survives
    ifr3_next[IFR3_CK48_BIT] = ck48_ready;
  end

  // RULE_01 interface reset starts set
  // RULE_05 core reset starts set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iface_rst_reg <= IFACE_RST_INIT;
      core_rst_reg  <= CORE_RST_INIT;
      ier3_reg      <= IER3_INIT;
      ifr3_reg      <= IFR3_INIT;
      vbus_d_reg    <= 1'b0;
    end
    else
    begin
      iface_rst_reg <= iface_rst_next;
      core_rst_reg  <= core_rst_next;
      ier3_reg      <= ier3_next;
      ifr3_reg      <= ifr3_next;
      vbus_d_reg    <= vbus_d_next;
    end
  end

  // ==========================================================================
  // APB read path
  // Read data is prepared in the setup cycle, so every access completes
  // with zero wait states while prdata still comes from a flip-flop.
  always_comb
  begin
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (setup)
    begin
      pslverr_next = !is_mapped(paddr);
      case (paddr)
        CTRL_OFF:
        begin
          prdata_next = ZERO_WORD;
          prdata_next[CTRL_IFACE_RST_BIT] = iface_rst_reg;
          prdata_next[CTRL_CORE_RST_BIT]  = core_rst_reg;
        end
        IER3_OFF: prdata_next = widen(ier3_reg);
        IFR3_OFF: prdata_next = widen(ifr3_reg);
        STAT_OFF:
        begin
          prdata_next = ZERO_WORD;
          prdata_next[STAT_VBUS_BIT] = vbus_on;
          prdata_next[STAT_CK48_BIT] = ck48_ready;
          prdata_next[STAT_SYNC_BIT] = sync_en_reg;
        end
        default: prdata_next = ZERO_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Reset outputs
  always_comb
  begin
    // RULE_06 bus sync stops
    sync_en_next = !core_rst_next && !iface_rst_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg    <= ZERO_WORD;
      pslverr_reg   <= 1'b0;
      pready_reg    <= 1'b0;
      iface_out_reg <= IFACE_RST_INIT;
      core_out_reg  <= CORE_RST_INIT;
      sync_en_reg   <= 1'b0;
    end
    else
    begin
      prdata_reg    <= prdata_next;
      pslverr_reg   <= pslverr_next;
      pready_reg    <= 1'b1;
      iface_out_reg <= iface_rst_next;
      // RULE_06 core held reset
      core_out_reg  <= core_rst_next;
      sync_en_reg   <= sync_en_next;
    end
  end

  assign prdata               = prdata_reg;
  assign pslverr              = pslverr_reg;
  assign pready               = pready_reg;
  assign interface_reset_out  = iface_out_reg;
  assign core_reset_out       = core_out_reg;
  assign bus_sync_enable      = sync_en_reg;
  assign interrupt_enable_out = ier3_reg;
endmodule // usbrs_seq

// ---- sim/usbrs_host_model.sv ----
`timescale 1ns/1ps
// ==========
// Cable host
// ==========
// The host powers VBUS only while the cable is attached.
module usbrs_host_model
(
  // Cable state
  input  wire logic attach,
  // Bus power
  output logic      vbus_pin
);
  assign vbus_pin = attach;
endmodule // usbrs_host_model

// ---- sim/usbrs_seq_chk.sv ----
`timescale 1ns/1ps
module usbrs_seq_chk
  import usbrs_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              interface_reset_out,
  input wire logic              core_reset_out,
  input wire logic              bus_sync_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite && paddr == CTRL_OFF;
  wire frc = wr && pwdata[CTRL_IFACE_RST_BIT] && !interface_reset_out;
  // ==========
  // Properties
  // ==========
  property p_start_held;
    $rose(presetn) |-> interface_reset_out && core_reset_out;
  endproperty
  a_start_held: assert property (p_start_held)
    else $error("reset outputs not set after reset");
  property p_iface_ctrl;
    wr |=> interface_reset_out == $past(pwdata[CTRL_IFACE_RST_BIT]);
  endproperty
  a_iface_ctrl: assert property (p_iface_ctrl)
    else $error("interface reset does not follow write");
  property p_force_core;
    frc |=> core_reset_out;
  endproperty
  a_force_core: assert property (p_force_core)
    else $error("core reset not forced");
  property p_core_ctrl;
    wr && !frc |=> core_reset_out == $past(pwdata[CTRL_CORE_RST_BIT]);
  endproperty
  a_core_ctrl: assert property (p_core_ctrl)
    else $error("core reset does not follow write");
  property p_sync_gate;
    bus_sync_enable == (!interface_reset_out && !core_reset_out);
  endproperty
  a_sync_gate: assert property (p_sync_gate)
    else $error("bus sync enabled during reset");
  property p_iface_hold;
    !wr |=> $stable(interface_reset_out);
  endproperty
  a_iface_hold: assert property (p_iface_hold)
    else $error("interface reset changed without a control write");
  property p_core_hold;
    !wr |=> $stable(core_reset_out);
  endproperty
  a_core_hold: assert property (p_core_hold)
    else $error("core reset changed without a control write");
endmodule // usbrs_seq_chk
bind usbrs_seq usbrs_seq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .interface_reset_out(interface_reset_out), .core_reset_out(core_reset_out),
  .bus_sync_enable(bus_sync_enable));

// ---- sim/test_usb_reset_sequencer.sv ----
`timescale 1ns/1ps
module test_usb_reset_sequencer
  import usbrs_pkg::*;
;
  logic        pclk            = 1'b0;
  logic        presetn         = 1'b0;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [7:0]  paddr           = 8'h00;
  logic [31:0] pwdata          = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        ck48            = 1'b0;
  logic        attach          = 1'b1;
  logic        vbus;
  logic        irst;
  logic        crst;
  logic        sync;
  logic [5:0]  evt             = 6'h00;
  logic [7:0]  ie;
  int          errors          = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  usbrs_host_model host (.attach(attach), .vbus_pin(vbus));
  usbrs_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk48_stable_pin(ck48), .vbus_pin(vbus), .usb_event(evt),
    .interface_reset_out(irst), .core_reset_out(crst), .bus_sync_enable(sync),
    .interrupt_enable_out(ie));
  initial forever #12.5 pclk = ~pclk;
  // ==========
  // Bus tasks
  // ==========
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, ZERO_WORD);
    chk(rd, e);
  endtask
  // Reset outputs are read on the falling edge, well away from the edge that launches them.
  task automatic chk_outs(input logic [31:0] e);
    @(negedge pclk);
    chk({29'h0000_0000, irst, crst, sync}, e);
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge pclk);
    evt <= v;
    @(posedge pclk);
    evt <= 6'h00;
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Long enough for every test with a wide margin.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      conclude();
    end
  end
  // ==========
  // Tests
  // ==========
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(CTRL_OFF, 32'h0000_0003);
    rdc(STAT_OFF, 32'h0000_0001);
    chk_outs(32'h0000_0006);
    $display("test reset done");
    ck48 <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(IFR3_OFF, 32'h0000_0001);
    apb(1'b1, IER3_OFF, 32'h0000_00A5);
    pulse(6'h3F);
    rdc(IER3_OFF, 32'h0000_00A5);
    rdc(IFR3_OFF, 32'h0000_0001);
    chk({24'h00_0000, ie}, 32'h0000_00A5);
    $display("test iface reset done");
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    rdc(STAT_OFF, 32'h0000_0003);
    chk_outs(32'h0000_0002);
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    rdc(STAT_OFF, 32'h0000_0007);
    chk_outs(32'h0000_0001);
    pulse(6'h3F);
    rdc(IFR3_OFF, 32'h0000_00FD);
    apb(1'b1, IFR3_OFF, 32'h0000_00FC);
    rdc(IFR3_OFF, 32'h0000_0001);
    $display("test bring-up done");
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    chk_outs(32'h0000_0001);
    rdc(IER3_OFF, 32'h0000_00A5);
    $display("test suspend done");
    attach <= 1'b0;
    repeat (8) @(posedge pclk);
    rdc(IFR3_OFF, 32'h0000_0003);
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    rdc(STAT_OFF, 32'h0000_0002);
    chk_outs(32'h0000_0002);
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    apb(1'b1, CTRL_OFF, 32'h0000_0002);
    rdc(CTRL_OFF, 32'h0000_0003);
    chk_outs(32'h0000_0006);
    $display("test detach done");
    rdc(8'h10, ZERO_WORD);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    $display("test unmapped done");
    conclude();
  end
endmodule // test_usb_reset_sequencer
